// ---- src/ssp_pins.sv ----
`timescale 1ns/1ns
`default_nettype none

module ssp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // port enable from the power gate
    input  wire logic         en_i,
    // fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // refuse depths the pointer wrap cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad_fifo
        $error("fifo depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    rdy;
    } ssp_fifo_type;

    ssp_fifo_type s_ff;
    ssp_fifo_type nxt_s;
    logic         push;
    logic         pop;

    // push and pop only while the port is powered
    always_comb begin
        push  = in_valid_i && s_ff.rdy && en_i;
        pop   = out_ready_i && (s_ff.cnt != '0) && en_i;
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data_i;
            nxt_s.wp           = s_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_s.rp = s_ff.rp + 1'b1;
        end
        nxt_s.cnt = s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        nxt_s.rdy = en_i && (nxt_s.cnt != (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign in_ready_o  = s_ff.rdy;
    assign out_valid_o = s_ff.cnt != '0;
    assign out_data_o  = s_ff.mem[s_ff.rp];

endmodule

module ssp_pins
    import ssp_pkg::*;
#(
    parameter int DW       = ssp_pkg::SSP_DATA_W,
    parameter int DEPTH    = ssp_pkg::SSP_FIFO_DEPTH,
    parameter int HALF_CYC = ssp_pkg::SSP_SCK_HALF_CYC
) (
    // core clock and reset
    input  wire logic                         CORE_CLK_I,
    input  wire logic                         ARST_N_I,
    // serial clock pin as received, clocks the slave shifter
    input  wire logic                         SCK_LINK_CLK_I,
    // peripheral power gate word
    input  wire logic                         GATE_WR_I,
    input  wire logic [ssp_pkg::SSP_GATE_W-1:0] GATE_WDATA_I,
    output logic                              PORT_POWER_O,
    output logic                              LEGACY_POWER_O,
    // configuration
    input  wire ssp_pkg::ssp_cfg_type         CFG_I,
    input  wire logic [DW-1:0]                SLV_TX_I,
    // transmit stream for master frames
    input  wire logic                         TX_VALID_I,
    input  wire logic [DW-1:0]                TX_DATA_I,
    output logic                              TX_READY_O,
    // received words and status
    output logic                              RX_VALID_O,
    output logic [DW-1:0]                     RX_DATA_O,
    input  wire logic                         RX_ACK_I,
    output logic                              RX_OVR_O,
    input  wire logic                         FLAG_CLR_I,
    output logic                              BUSY_O,
    // serial clock pin
    output logic                              SCK_O,
    output logic                              SCK_OE_O,
    // select / frame sync pin
    input  wire logic                         SEL_I,
    output logic                              SEL_O,
    output logic                              SEL_OE_O,
    // master-in pin
    input  wire logic                         MISO_I,
    output logic                              MISO_O,
    output logic                              MISO_OE_O,
    // master-out pin
    input  wire logic                         MOSI_I,
    output logic                              MOSI_O,
    output logic                              MOSI_OE_O
);
    import ssp_pkg::*;

    localparam int EW = $clog2(2 * DW) + 1;
    localparam int CW = $clog2(HALF_CYC + 1) + 1;
    localparam int BW = $clog2(DW) + 1;

    // master-in passes two flops, so a half period under 3 samples stale
    if (DW < 4 || DW > 16 || HALF_CYC < 3) begin : g_bad_cfg
        $error("frame width must be 4 to 16 bits, half period >= 3");
    end

    // core domain state
    typedef struct packed {
        logic              legacy;
        logic              port;
        ssp_mst_type       st;
        logic [CW-1:0]     div;
        logic [EW-1:0]     edges;
        logic [DW-1:0]     sh;
        logic [DW-1:0]     rx;
        logic              sck;
        logic              sck_oe;
        logic              sel;
        logic              sel_oe;
        logic              mosi_oe;
        logic              miso_oe;
        logic              rx_valid;
        logic [DW-1:0]     rx_data;
        logic              ovr;
        logic              miso_q1;
        logic              miso_q2;
        logic              sel_q1;
        logic              sel_q2;
        logic              tog_q1;
        logic              tog_q2;
        logic              tog_q3;
        logic              busy;
    } ssp_core_type;

    // link domain state
    typedef struct packed {
        logic              pwr_q1;
        logic              pwr_q2;
        logic              armed;
        logic [BW-1:0]     cnt;
        logic [DW-1:0]     rx;
        logic [DW-1:0]     tx;
        logic [DW-1:0]     word;
        logic              tog;
    } ssp_link_type;

    ssp_core_type c_ff;
    ssp_core_type nxt_c;
    ssp_link_type l_ff;
    ssp_link_type nxt_l;

    logic          fifo_valid;
    logic [DW-1:0] fifo_data;
    logic          fifo_pop;
    logic          pol;
    logic          cpha;
    logic          sel_act;
    logic          tick;
    logic          lead;
    logic          samp;
    logic          shft;
    logic          last;

    // transmit words wait here until a master frame takes one
    assign fifo_pop = c_ff.port && CFG_I.master && (c_ff.st == SSP_MST_IDLE);

    ssp_fifo #(
        .W     (DW),
        .DEPTH (DEPTH)
    ) u_txq (
        .clk_i       (CORE_CLK_I),
        .arst_n_i    (ARST_N_I),
        .en_i        (c_ff.port),
        .in_valid_i  (TX_VALID_I),
        .in_data_i   (TX_DATA_I),
        .in_ready_o  (TX_READY_O),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    // format decode: clock polarity, phase and select level
    always_comb begin
        pol     = (CFG_I.fmt == SSP_FMT_SPI) ? CFG_I.cpol : 1'b0;
        cpha    = (CFG_I.fmt == SSP_FMT_SPI)   ? CFG_I.cpha :
                  (CFG_I.fmt == SSP_FMT_FSYNC);
        sel_act = CFG_I.fmt == SSP_FMT_FSYNC;
        tick    = c_ff.div == CW'(HALF_CYC - 1);
        lead    = ~c_ff.edges[0];
        samp    = cpha ? ~lead : lead;
        last    = c_ff.edges == EW'(2 * DW - 1);
        shft    = cpha ? (lead && c_ff.edges != '0) : (~lead && !last);
    end

    // core next state
    always_comb begin
        nxt_c          = c_ff;
        nxt_c.miso_q1  = MISO_I;
        nxt_c.miso_q2  = c_ff.miso_q1;
        nxt_c.sel_q1   = SEL_I;
        nxt_c.sel_q2   = c_ff.sel_q1;
        nxt_c.tog_q1   = l_ff.tog;
        nxt_c.tog_q2   = c_ff.tog_q1;
        nxt_c.tog_q3   = c_ff.tog_q2;
        // legacy unit wins when both are asked for
        if (GATE_WR_I) begin
            nxt_c.legacy = GATE_WDATA_I[SSP_LEGACY_BIT];
            nxt_c.port   = GATE_WDATA_I[SSP_PORT_BIT] &&
                           !GATE_WDATA_I[SSP_LEGACY_BIT];
        end
        // with the gate clear nothing below moves, flags included
        if (c_ff.port) begin
            case (c_ff.st)
                SSP_MST_IDLE: begin
                    nxt_c.sck = pol;
                    nxt_c.sel = ~sel_act;
                    nxt_c.div = '0;
                    if (fifo_pop && fifo_valid) begin
                        nxt_c.sh    = fifo_data;
                        nxt_c.edges = '0;
                        nxt_c.sel   = sel_act;
                        nxt_c.st    = SSP_MST_LEAD;
                    end
                end
                SSP_MST_LEAD: begin
                    nxt_c.div = c_ff.div + 1'b1;
                    if (tick) begin
                        nxt_c.div = '0;
                        nxt_c.st  = SSP_MST_SHIFT;
                    end
                end
                SSP_MST_SHIFT: begin
                    nxt_c.div = c_ff.div + 1'b1;
                    if (tick) begin
                        nxt_c.div   = '0;
                        nxt_c.sck   = ~c_ff.sck;
                        nxt_c.edges = c_ff.edges + 1'b1;
                        if (sel_act) begin
                            nxt_c.sel = 1'b0;
                        end
                        if (samp) begin
                            nxt_c.rx = {c_ff.rx[DW-2:0], c_ff.miso_q2};
                        end
                        if (shft) begin
                            nxt_c.sh = {c_ff.sh[DW-2:0], 1'b0};
                        end
                        if (last) begin
                            nxt_c.st = SSP_MST_TRAIL;
                        end
                    end
                end
                SSP_MST_TRAIL: begin
                    nxt_c.div = c_ff.div + 1'b1;
                    if (tick) begin
                        nxt_c.div = '0;
                        nxt_c.sel = ~sel_act;
                        nxt_c.st  = SSP_MST_IDLE;
                    end
                end
                default: begin
                    nxt_c.st = SSP_MST_IDLE;
                end
            endcase
            // word delivery, acknowledge and overrun; set beats clear
            if (RX_ACK_I) begin
                nxt_c.rx_valid = 1'b0;
            end
            if (FLAG_CLR_I) begin
                nxt_c.ovr = 1'b0;
            end
            if (c_ff.st == SSP_MST_TRAIL && tick) begin
                nxt_c.rx_data  = c_ff.rx;
                nxt_c.rx_valid = 1'b1;
                nxt_c.ovr      = c_ff.ovr || c_ff.rx_valid;
            end else if (c_ff.tog_q3 != c_ff.tog_q2) begin
                nxt_c.rx_data  = l_ff.word;
                nxt_c.rx_valid = 1'b1;
                nxt_c.ovr      = c_ff.ovr || c_ff.rx_valid;
            end
        end
        // pin enables follow the gate and the role
        nxt_c.busy    = nxt_c.st != SSP_MST_IDLE;
        nxt_c.sck_oe  = nxt_c.port && CFG_I.master;
        nxt_c.sel_oe  = nxt_c.port && CFG_I.master;
        nxt_c.mosi_oe = nxt_c.port && CFG_I.master &&
                        nxt_c.st != SSP_MST_IDLE;
        nxt_c.miso_oe = nxt_c.port && !CFG_I.master &&
                        CFG_I.fmt != SSP_FMT_FSYNC &&
                        !c_ff.sel_q2;
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            c_ff        <= '0;
            c_ff.legacy <= SSP_LEGACY_RST;
            c_ff.port   <= SSP_PORT_RST;
            c_ff.sel    <= 1'b1;
        end else begin
            c_ff <= nxt_c;
        end
    end

    // slave shifter, clocked by the received serial clock
    always_comb begin
        nxt_l        = l_ff;
        nxt_l.pwr_q1 = c_ff.port;
        nxt_l.pwr_q2 = l_ff.pwr_q1;
        if (l_ff.pwr_q2 && !CFG_I.master) begin
            if (CFG_I.fmt == SSP_FMT_FSYNC ? SEL_I : SEL_I == 1'b1) begin
                // frame pulse or deselected: restart the word
                nxt_l.armed = CFG_I.fmt == SSP_FMT_FSYNC;
                nxt_l.cnt   = '0;
                nxt_l.tx    = SLV_TX_I;
            end else if (CFG_I.fmt != SSP_FMT_FSYNC || l_ff.armed) begin
                nxt_l.rx  = {l_ff.rx[DW-2:0], MOSI_I};
                nxt_l.tx  = {l_ff.tx[DW-2:0], 1'b0};
                nxt_l.cnt = l_ff.cnt + 1'b1;
                if (l_ff.cnt == BW'(DW - 1)) begin
                    nxt_l.word  = {l_ff.rx[DW-2:0], MOSI_I};
                    nxt_l.tog   = ~l_ff.tog;
                    nxt_l.cnt   = '0;
                    nxt_l.tx    = SLV_TX_I;
                    nxt_l.armed = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge SCK_LINK_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            l_ff <= '0;
        end else begin
            l_ff <= nxt_l;
        end
    end

    // outputs straight from flops
    assign PORT_POWER_O   = c_ff.port;
    assign LEGACY_POWER_O = c_ff.legacy;
    assign RX_VALID_O     = c_ff.rx_valid;
    assign RX_DATA_O      = c_ff.rx_data;
    assign RX_OVR_O       = c_ff.ovr;
    assign BUSY_O         = c_ff.busy;
    assign SCK_O          = c_ff.sck;
    assign SCK_OE_O       = c_ff.sck_oe;
    assign SEL_O          = c_ff.sel;
    assign SEL_OE_O       = c_ff.sel_oe;
    assign MOSI_O         = c_ff.sh[DW-1];
    assign MOSI_OE_O      = c_ff.mosi_oe;
    assign MISO_O         = l_ff.tx[DW-1];
    assign MISO_OE_O      = c_ff.miso_oe;

    // checks on the core domain
    default clocking ast_cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    sequence gate_both_s;
        GATE_WR_I && GATE_WDATA_I[SSP_LEGACY_BIT] &&
        GATE_WDATA_I[SSP_PORT_BIT];
    endsequence

    sequence frame_start_s;
        c_ff.st == SSP_MST_IDLE ##1 c_ff.st == SSP_MST_LEAD;
    endsequence

    AST_GATE_EXCL: assert property (
        !(PORT_POWER_O && LEGACY_POWER_O))
        else $error("both units powered");

    AST_GATE_BOTH: assert property (
        gate_both_s |=> LEGACY_POWER_O && !PORT_POWER_O)
        else $error("double gate write not resolved to legacy");

    AST_OFF_NODRIVE: assert property (
        !PORT_POWER_O |-> !(SCK_OE_O || SEL_OE_O || MOSI_OE_O ||
                            MISO_OE_O))
        else $error("pin driven while gate clear");

    AST_OFF_FREEZE: assert property (
        !PORT_POWER_O ##1 !PORT_POWER_O |->
        $stable(RX_DATA_O) && $stable(RX_VALID_O) && $stable(BUSY_O))
        else $error("state moved while gate clear");

    AST_OVR_HOLD: assert property (
        RX_OVR_O && !PORT_POWER_O |=> RX_OVR_O)
        else $error("flag lost while gate clear");

    AST_SCK_IDLE: assert property (
        c_ff.st == SSP_MST_IDLE && $past(c_ff.st) == SSP_MST_IDLE &&
        $stable(CFG_I) && PORT_POWER_O |->
        SCK_O == ((CFG_I.fmt == SSP_FMT_SPI) ? CFG_I.cpol : 1'b0))
        else $error("serial clock not at idle level");

    AST_SEL_FRAME: assert property (
        frame_start_s ##0 $stable(CFG_I) |->
        SEL_O == (CFG_I.fmt == SSP_FMT_FSYNC))
        else $error("select not asserted at frame start");

    AST_FRAME_LEN: assert property (
        frame_start_s |-> ##[1:300] $fell(BUSY_O))
        else $error("master frame did not finish");

    AST_MISO_HIZ: assert property (
        !CFG_I.master && $stable(CFG_I) && c_ff.sel_q2 |=> !MISO_OE_O)
        else $error("master-in driven while deselected");

    AST_MOSI_ROLE: assert property (
        MOSI_OE_O |-> BUSY_O && $past(CFG_I.master))
        else $error("master-out driven outside a master frame");

endmodule

`default_nettype wire

// ---- pkg/ssp_pkg.sv ----
// Summary of operation
// - With the port's power gate at zero the port's state is frozen, so reads show the held word and flags and writes are lost.
// - Flags that were set when the gate closed stay set and keep requesting service.
// - The master makes the serial clock for every transfer and the slave shifts on the clock it receives.
// - The clock's idle level is programmable in the four-wire select format and fixed active high otherwise.
// - The serial clock toggles only during a transfer and otherwise rests at its idle level or is undriven.
// - As master the port asserts select from just before the first bit to just after the last, and frame sync for the two half periods before the first clock edge.
// - As slave the port only takes data while its select or frame sync input qualifies the frame.
// - On the master-in line the port drives data as slave, except in the frame sync format, and samples data as master.
// - A slave that is not selected leaves the master-in line undriven.
// - On the master-out line the port drives data as master and samples data as slave.
// - This port and the legacy unit are never powered together; writing both gate bits high favours the legacy unit.
// - After reset the legacy unit is powered and this port's gate is clear.
package ssp_pkg;

    // frame formats and master sequencer states
    typedef enum logic [1:0] {
        SSP_FMT_SPI,
        SSP_FMT_FSYNC,
        SSP_FMT_SEL3
    } ssp_fmt_type;

    typedef enum logic [1:0] {
        SSP_MST_IDLE,
        SSP_MST_LEAD,
        SSP_MST_SHIFT,
        SSP_MST_TRAIL
    } ssp_mst_type;

    // static configuration seen by both clock domains
    typedef struct packed {
        logic        master;
        logic        cpol;
        logic        cpha;
        ssp_fmt_type fmt;
    } ssp_cfg_type;

    // gate word bit positions and reset values
    localparam int   SSP_GATE_W         = 32;
    localparam int   SSP_LEGACY_BIT     = 10;
    localparam int   SSP_PORT_BIT       = 21;
    localparam logic SSP_LEGACY_RST     = 1'b1;
    localparam logic SSP_PORT_RST       = 1'b0;

    // data path sizes
    localparam int   SSP_DATA_W         = 8;
    localparam int   SSP_FIFO_DEPTH     = 8;

    // serial clock timing: half period as a least time
    localparam int   SSP_CORE_CLK_PS    = 4000;
    localparam int   SSP_SCK_HALF_NS    = 16;
    localparam int   SSP_SCK_HALF_CYC   =
        (SSP_SCK_HALF_NS * 1000 + SSP_CORE_CLK_PS - 1) / SSP_CORE_CLK_PS;

endpackage

// ---- dv/ssp_far_slave.sv ----
`timescale 1ns/1ns
`default_nettype none

module ssp_far_slave (
    // pins seen from the far side
    input  wire logic       sck_i,
    input  wire logic       sel_n_i,
    input  wire logic       mosi_i,
    input  wire logic       cpol_i,
    output logic            miso_o,
    // word sent back and word taken
    input  wire logic [7:0] tx_i,
    output logic [7:0]      rx_o
);
    logic [7:0] sh_ff = '0;
    logic       last_ff = 1'b0;
    wire  logic lead = sck_i ^ cpol_i;

    // capture on the leading edge, msb first
    always @(posedge lead) begin
        if (!sel_n_i) rx_o <= {rx_o[6:0], mosi_i};
    end

    // load on select, move on the trailing edge
    always @(negedge sel_n_i) begin
        sh_ff = tx_i;
        last_ff = sh_ff[7];
    end
    always @(negedge lead) begin
        if (!sel_n_i) begin
            sh_ff = {sh_ff[6:0], 1'b0};
            last_ff = sh_ff[7];
        end
    end

    // released line shows the inverse of the last bit
    assign miso_o = sel_n_i ? ~last_ff : sh_ff[7];
endmodule

`default_nettype wire

// ---- dv/ssp_pins_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

module ssp_pins_bench;
    import ssp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        lclk = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = '0;
    ssp_cfg_type cfg = '0;
    logic        tv = 1'b0;
    logic [7:0]  td = '0;
    logic        ack = 1'b0;
    logic        fclr = 1'b0;
    logic        sel_d = 1'b1;
    logic        mosi_d = 1'b0;
    logic        fpol = 1'b0;
    logic [7:0]  ftx = '0;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    wire logic [7:0] frx;
    wire logic [7:0] rxd;
    wire logic   fmiso, ppw, lpw, trdy, rxv, ovr, busy;
    wire logic   sck, sck_oe, sel, sel_oe, miso, miso_oe, mosi, mosi_oe;
    wire logic   sck_p = sck_oe ? sck : lclk;
    wire logic   sel_p = sel_oe ? sel : sel_d;
    wire logic   miso_p = miso_oe ? miso : fmiso;
    wire logic   mosi_p = mosi_oe ? mosi : mosi_d;
    // gate rows {legacy, port, exp port, exp legacy}
    logic [3:0]  rows[4] = '{4'b0110, 4'b1101, 4'b0000, 4'b1001};
    // master modes {fmt, cpol}
    logic [2:0]  modes[4] = '{3'b000, 3'b001, 3'b101, 3'b011};

    ssp_pins #(.HALF_CYC(4)) dut (
        .CORE_CLK_I(clk), .ARST_N_I(rst_n), .SCK_LINK_CLK_I(sck_p),
        .GATE_WR_I(wr), .GATE_WDATA_I(wd), .PORT_POWER_O(ppw),
        .LEGACY_POWER_O(lpw), .CFG_I(cfg), .SLV_TX_I(8'h96),
        .TX_VALID_I(tv), .TX_DATA_I(td), .TX_READY_O(trdy),
        .RX_VALID_O(rxv), .RX_DATA_O(rxd), .RX_ACK_I(ack),
        .RX_OVR_O(ovr), .FLAG_CLR_I(fclr), .BUSY_O(busy),
        .SCK_O(sck), .SCK_OE_O(sck_oe), .SEL_I(sel_p), .SEL_O(sel),
        .SEL_OE_O(sel_oe), .MISO_I(miso_p), .MISO_O(miso),
        .MISO_OE_O(miso_oe), .MOSI_I(mosi_p), .MOSI_O(mosi),
        .MOSI_OE_O(mosi_oe)
    );

    ssp_far_slave far (
        .sck_i(sck_p), .sel_n_i(sel_p), .mosi_i(mosi_p), .cpol_i(fpol),
        .miso_o(fmiso), .tx_i(ftx), .rx_o(frx)
    );

    // core clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    // one gate word write
    task automatic gate(input logic leg, input logic prt);
        @(negedge clk);
        wd = '0;
        wd[SSP_LEGACY_BIT] = leg;
        wd[SSP_PORT_BIT] = prt;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic ackp();
        @(negedge clk);
        ack = 1'b1;
        @(negedge clk);
        ack = 1'b0;
        @(negedge clk);
    endtask

    // one link clock period carrying one bit
    task automatic lbit(input logic b);
        mosi_d = b;
        #62 lclk = 1'b1;
        #63 lclk = 1'b0;
    endtask

    // one master frame, counting clock toggles in and out of it
    task automatic mframe(input logic [2:0] m, input logic [7:0] d);
        int k;
        int ein;
        int eout;
        logic s0;
        logic ip;
        ip = (m[2:1] == 2'd0) & m[0];
        cfg.fmt = ssp_fmt_type'(m[2:1]);
        cfg.cpol = m[0];
        fpol = ip;
        ftx = ~d;
        ein = 0;
        eout = 0;
        repeat (3) @(negedge clk);
        tv = 1'b1;
        td = d;
        @(negedge clk);
        tv = 1'b0;
        s0 = sck;
        for (k = 0; k < 300 && rxv !== 1'b1; k++) begin
            @(negedge clk);
            if (sck !== s0 && busy === 1'b1) ein++;
            if (sck !== s0 && busy !== 1'b1) eout++;
            s0 = sck;
        end
        chk_byte(8'(ein), 8'd16);
        chk_byte(8'(eout), 8'd0);
        chk_bit(sck, ip);
        chk_bit(sel, m[2:1] != 2'd1);
        chk_bit(mosi_oe, 1'b0);
        if (m[2:1] != 2'd1) begin
            chk_byte(rxd, ~d);
            chk_byte(frx, d);
        end
        ackp();
        chk_bit(rxv, 1'b0);
    endtask

    initial begin
        int i;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk_bit(lpw, 1'b1);
        chk_bit(ppw, 1'b0);
        chk_byte({sck_oe, sel_oe, miso_oe, mosi_oe}, 8'h00);
        cfg.master = 1'b1;
        for (i = 0; i < 4; i++) begin
            gate(rows[i][3], rows[i][2]);
            @(negedge clk);
            chk_bit(ppw, rows[i][1]);
            chk_bit(lpw, rows[i][0]);
            chk_byte({sck_oe, sel_oe, miso_oe, mosi_oe},
                     {4'h0, rows[i][1], rows[i][1], 2'b00});
        end
        gate(1'b0, 1'b1);
        for (i = 0; i < 4; i++) mframe(modes[i], 8'ha5 ^ 8'(i));
        // slave: junk edges while deselected must not count
        cfg = '0;
        repeat (3) lbit(1'b1);
        @(negedge clk);
        sel_d = 1'b0;
        repeat (6) @(negedge clk);
        chk_bit(miso_oe, 1'b1);
        for (i = 7; i >= 0; i--) begin
            chk_bit(miso, 1'(8'h96 >> i));
            lbit(1'(8'h5a >> i));
        end
        #60;
        @(negedge clk);
        sel_d = 1'b1;
        for (i = 0; i < 50 && rxv !== 1'b1; i++) @(negedge clk);
        chk_bit(rxv, 1'b1);
        chk_byte(rxd, 8'h5a);
        repeat (6) @(negedge clk);
        chk_bit(miso_oe, 1'b0);
        // master word on top of the pending one raises overrun
        cfg.master = 1'b1;
        tv = 1'b1;
        @(negedge clk);
        tv = 1'b0;
        for (i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
        for (i = 0; i < 300 && busy === 1'b1; i++) @(negedge clk);
        chk_bit(ovr, 1'b1);
        // gate closed with flags pending: acknowledge and clear are lost
        gate(1'b1, 1'b0);
        fclr = 1'b1;
        ackp();
        chk_bit(rxv, 1'b1);
        chk_bit(ovr, 1'b1);
        chk_byte({sck_oe, sel_oe, miso_oe, mosi_oe}, 8'h00);
        gate(1'b0, 1'b1);
        ackp();
        fclr = 1'b0;
        chk_bit(rxv, 1'b0);
        chk_bit(ovr, 1'b0);
        gate(1'b1, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
